// ### design/cdr_regs.sv
/*
 * cdr_regs: dedicated register set of an 8-bit core with flag logic,
 * direct-window mapping, bank register addressing and interrupt gating.
 * Assumes the core drives its request inputs from logic on sys_clk.
 */
// Added by the designer: the placing of the registers and the address-and-strobe port.
// Functional notes
// - 16-bit instruction_pointer holds the fetch location, advanced by pc_step.
// - 16-bit accumulator; byte operations touch only its low byte.
// - 16-bit temporary accumulator is second operand; byte ops use low byte.
// - 16-bit index, extra memory pointer and stack top pointer registers.
// - status word upper byte holds bank and window pointers, lower byte flags.
// - direct addresses 0080-00ff remapped by window code; 0000-007f never.
// - window code zero leaves window; code n maps to 0080 plus n times 0080.
// - half-carry flag follows carry or borrow between bit 3 and bit 4.
// - interrupt enable flag gates requests; reset clears it.
// - request accepted only when its level is below the current level.
// - negative flag copies result msb.
// - zero flag set on zero result, cleared otherwise.
// - overflow flag set on two's complement overflow.
// - carry flag from carry or borrow out of msb; shift gives shifted-out bit.
// - general registers are 8-bit memory bytes, eight per bank, 32 banks.
// - opcode low three bits select register within active bank.
`timescale 1ns/100ps
module cdr_regs import cdr_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// register port
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// core control
	input wire logic pc_step,
	input wire logic op_go,
	input wire logic op_word,
	input wire logic op_sub,
	input wire logic op_shift,
	// direct address mapping
	input wire logic dir_req,
	input wire logic [7:0] dir_addr,
	output logic [15:0] map_addr,
	// bank register addressing
	input wire logic gpr_req,
	input wire logic [7:0] gpr_opcode,
	output logic [15:0] gpr_addr,
	// interrupt gating
	input wire logic irq_req,
	input wire logic [1:0] irq_level,
	output logic irq_accept,
	// register views
	output logic [15:0] pc_out,
	output logic [15:0] acc_out,
	output logic [15:0] ix_out,
	output logic [15:0] ep_out,
	output logic [15:0] sp_out,
	output logic [15:0] psw_out
);
	cdr_state_type st_reg;
	cdr_state_type st_next;

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb begin
		logic [15:0] b_eff;
		logic [16:0] s17;
		logic [8:0] s9;
		logic [4:0] s5;
		logic [15:0] res;
		logic a_s;
		logic b_s;
		logic r_s;
		b_eff = op_sub ? ~st_reg.tmp : st_reg.tmp;
		s17 = {1'b0, st_reg.acc} + {1'b0, b_eff} + {16'h0000, op_sub};
		s9 = {1'b0, st_reg.acc[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, op_sub};
		s5 = {1'b0, st_reg.acc[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, op_sub};
		res = 16'h0000;
		a_s = 1'b0;
		b_s = 1'b0;
		r_s = 1'b0;
		st_next = st_reg;
		st_next.rdata = 16'h0000;
		// fetch pointer advance, a software write below takes over
		if (pc_step) begin
			st_next.pc = st_reg.pc + 16'h0001;
		end
		// software writes; unmapped index ignored
		if (reg_wr) begin
			case (reg_addr)
				IDX_PC: st_next.pc = reg_wdata;
				IDX_ACC: st_next.acc = reg_wdata;
				IDX_TMP: st_next.tmp = reg_wdata;
				IDX_IX: st_next.ix = reg_wdata;
				IDX_EP: st_next.ep = reg_wdata;
				IDX_SP: st_next.sp = reg_wdata;
				IDX_PSW: begin
					st_next.rp = reg_wdata[15:11];
					st_next.dp = reg_wdata[10:8];
					st_next.condition_flags = reg_wdata[7:0];
				end
				default: st_next.pc = st_next.pc;
			endcase
		end
		// read data stands in the following cycle only
		if (reg_rd) begin
			case (reg_addr)
				IDX_PC: st_next.rdata = st_reg.pc;
				IDX_ACC: st_next.rdata = st_reg.acc;
				IDX_TMP: st_next.rdata = st_reg.tmp;
				IDX_IX: st_next.rdata = st_reg.ix;
				IDX_EP: st_next.rdata = st_reg.ep;
				IDX_SP: st_next.rdata = st_reg.sp;
				IDX_PSW: st_next.rdata = {st_reg.rp, st_reg.dp, st_reg.condition_flags};
				default: st_next.rdata = 16'h0000;
			endcase
		end
		// arithmetic and shift; flag updates win over a software write
		if (op_go) begin
			if (op_shift) begin
				res = op_word ? {st_reg.acc[14:0], 1'b0} : {8'h00, st_reg.acc[6:0], 1'b0};
				st_next.condition_flags[CCR_C] = op_word ? st_reg.acc[15] : st_reg.acc[7];
			end else begin
				res = op_word ? s17[15:0] : {8'h00, s9[7:0]};
				st_next.condition_flags[CCR_C] = (op_word ? s17[16] : s9[8]) ^ op_sub;
				st_next.condition_flags[CCR_H] = s5[4] ^ op_sub;
				a_s = op_word ? st_reg.acc[15] : st_reg.acc[7];
				b_s = op_word ? b_eff[15] : b_eff[7];
				r_s = op_word ? res[15] : res[7];
				st_next.condition_flags[CCR_V] = (a_s == b_s) && (r_s != a_s);
			end
			st_next.condition_flags[CCR_N] = op_word ? res[15] : res[7];
			st_next.condition_flags[CCR_Z] = op_word ? (res == 16'h0000) : (res[7:0] == 8'h00);
			if (op_word) begin
				st_next.acc = res;
			end else begin
				st_next.acc = {st_reg.acc[15:8], res[7:0]};
			end
		end
		// direct window mapping
		if (dir_req) begin
			if (!dir_addr[7] || st_reg.dp == 3'h0) begin
				st_next.map_addr = {8'h00, dir_addr};
			end else begin
				st_next.map_addr = DIR_WIN_BASE + {6'h00, st_reg.dp, 7'h00}
					+ {9'h000, dir_addr[6:0]};
			end
		end
		// bank register address
		if (gpr_req) begin
			st_next.gpr_addr = GPR_BASE + {8'h00, st_reg.rp, gpr_opcode[2:0]};
		end
		// interrupt acceptance by enable and level
		st_next.irq_accept = irq_req && st_reg.condition_flags[CCR_I]
			&& (irq_level < st_reg.condition_flags[CCR_IL_HI:CCR_IL_LO]);
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_reg.pc <= REG_RESET;
			st_reg.acc <= REG_RESET;
			st_reg.tmp <= REG_RESET;
			st_reg.ix <= REG_RESET;
			st_reg.ep <= REG_RESET;
			st_reg.sp <= REG_RESET;
			st_reg.rp <= RP_RESET;
			st_reg.dp <= DP_RESET;
			st_reg.condition_flags <= CCR_RESET;
			st_reg.rdata <= REG_RESET;
			st_reg.map_addr <= REG_RESET;
			st_reg.gpr_addr <= REG_RESET;
			st_reg.irq_accept <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from state
	assign reg_rdata = st_reg.rdata;
	assign map_addr = st_reg.map_addr;
	assign gpr_addr = st_reg.gpr_addr;
	assign irq_accept = st_reg.irq_accept;
	assign pc_out = st_reg.pc;
	assign acc_out = st_reg.acc;
	assign ix_out = st_reg.ix;
	assign ep_out = st_reg.ep;
	assign sp_out = st_reg.sp;
	assign psw_out = {st_reg.rp, st_reg.dp, st_reg.condition_flags};

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_pc_step_adv: assert property (@(posedge sys_clk) disable iff (sys_rst)
		pc_step && !(reg_wr && reg_addr == IDX_PC) |=> pc_out == $past(pc_out) + 16'h0001)
		else $error("program pointer did not advance");
	a_byte_upper_kept: assert property (@(posedge sys_clk) disable iff (sys_rst)
		op_go && !op_word |=> acc_out[15:8] == $past(acc_out[15:8]))
		else $error("byte operation changed accumulator upper byte");
	a_psw_read_back: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_rd && reg_addr == IDX_PSW |=> reg_rdata == $past(psw_out))
		else $error("status word read mismatch");
	a_dir_low_fixed: assert property (@(posedge sys_clk) disable iff (sys_rst)
		dir_req && !dir_addr[7] |=> map_addr == {8'h00, $past(dir_addr)})
		else $error("low direct address was remapped");
	a_dir_window_map: assert property (@(posedge sys_clk) disable iff (sys_rst)
		dir_req && dir_addr[7] |=> map_addr == ($past(psw_out[10:8]) == 3'h0
		? {8'h00, $past(dir_addr)}
		: {6'h00, $past(psw_out[10:8]), $past(dir_addr[6:0])} + DIR_WIN_BASE))
		else $error("direct window mapped wrongly");
	a_irq_blocked: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!psw_out[CCR_I] |=> !irq_accept)
		else $error("interrupt accepted while disabled");
	a_irq_level_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
		irq_req && psw_out[CCR_I] |=> irq_accept == ($past(irq_level) < $past(psw_out[5:4])))
		else $error("interrupt level gating wrong");
	a_neg_flag_msb: assert property (@(posedge sys_clk) disable iff (sys_rst)
		op_go |=> psw_out[CCR_N] == ($past(op_word) ? acc_out[15] : acc_out[7]))
		else $error("negative flag does not match result");
	a_zero_flag_res: assert property (@(posedge sys_clk) disable iff (sys_rst)
		op_go && op_word |=> psw_out[CCR_Z] == (acc_out == 16'h0000))
		else $error("zero flag does not match result");
	a_shift_carry_out: assert property (@(posedge sys_clk) disable iff (sys_rst)
		op_go && op_shift && op_word |=> psw_out[CCR_C] == $past(acc_out[15]))
		else $error("shift carry wrong");
	a_gpr_bank_addr: assert property (@(posedge sys_clk) disable iff (sys_rst)
		gpr_req |=> gpr_addr == GPR_BASE + {8'h00, $past(psw_out[15:11]), $past(gpr_opcode[2:0])})
		else $error("bank register address wrong");

	// reset values seen one cycle after a sampled reset
	a_reset_flags_init: assert property (@(posedge sys_clk)
		sys_rst |=> psw_out == {RP_RESET, DP_RESET, CCR_RESET})
		else $error("status word not at reset value");
	a_reset_regs_zero: assert property (@(posedge sys_clk)
		sys_rst |=> pc_out == REG_RESET && acc_out == REG_RESET && sp_out == REG_RESET)
		else $error("register not cleared by reset");

	// software writes land one cycle later
	a_pc_write_wins: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_wr && reg_addr == IDX_PC |=> pc_out == $past(reg_wdata))
		else $error("program pointer write lost");
	a_pc_hold_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!pc_step && !(reg_wr && reg_addr == IDX_PC) |=> pc_out == $past(pc_out))
		else $error("program pointer moved without request");
	a_acc_write_lands: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_wr && reg_addr == IDX_ACC && !op_go |=> acc_out == $past(reg_wdata))
		else $error("accumulator write lost");
	a_ix_write_lands: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_wr && reg_addr == IDX_IX |=> ix_out == $past(reg_wdata))
		else $error("index register write lost");
	a_ep_write_lands: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_wr && reg_addr == IDX_EP |=> ep_out == $past(reg_wdata))
		else $error("extra pointer write lost");
	a_sp_write_lands: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_wr && reg_addr == IDX_SP |=> sp_out == $past(reg_wdata))
		else $error("stack pointer write lost");
	a_psw_write_lands: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_wr && reg_addr == IDX_PSW && !op_go |=> psw_out == $past(reg_wdata))
		else $error("status word write lost");

	// read data stand one cycle only
	a_tmp_read_back: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_rd && reg_addr == IDX_TMP |=> reg_rdata == $past(st_reg.tmp))
		else $error("temporary accumulator read mismatch");
	a_read_idle_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data stood without a read");

	// flag results of add and shift
	a_half_carry_add: assert property (@(posedge sys_clk) disable iff (sys_rst)
		op_go && !op_shift && !op_sub |=> psw_out[CCR_H]
		== (({1'b0, $past(acc_out[3:0])} + {1'b0, $past(st_reg.tmp[3:0])}) > 5'h0f))
		else $error("half carry wrong on add");
	a_carry_byte_add: assert property (@(posedge sys_clk) disable iff (sys_rst)
		op_go && !op_shift && !op_sub && !op_word |=> psw_out[CCR_C]
		== (({1'b0, $past(acc_out[7:0])} + {1'b0, $past(st_reg.tmp[7:0])}) > 9'h0ff))
		else $error("carry wrong on byte add");
	a_ovf_byte_add: assert property (@(posedge sys_clk) disable iff (sys_rst)
		op_go && !op_shift && !op_sub && !op_word |=> psw_out[CCR_V]
		== ($past(acc_out[7]) == $past(st_reg.tmp[7]) && acc_out[7] != $past(acc_out[7])))
		else $error("overflow wrong on byte add");
	a_zero_flag_byte: assert property (@(posedge sys_clk) disable iff (sys_rst)
		op_go && !op_word |=> psw_out[CCR_Z] == (acc_out[7:0] == 8'h00))
		else $error("zero flag wrong on byte result");
	a_shift_carry_byte: assert property (@(posedge sys_clk) disable iff (sys_rst)
		op_go && op_shift && !op_word |=> psw_out[CCR_C] == $past(acc_out[7]))
		else $error("byte shift carry wrong");
	a_shift_keeps_hv: assert property (@(posedge sys_clk) disable iff (sys_rst)
		op_go && op_shift && !(reg_wr && reg_addr == IDX_PSW) |=> psw_out[CCR_H]
		== $past(psw_out[CCR_H]) && psw_out[CCR_V] == $past(psw_out[CCR_V]))
		else $error("shift changed half carry or overflow");

	// mapping, banks and interrupts
	a_dir_map_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!dir_req |=> map_addr == $past(map_addr))
		else $error("mapped address changed without request");
	a_gpr_in_range: assert property (@(posedge sys_clk) disable iff (sys_rst)
		gpr_req |=> gpr_addr >= GPR_BASE && gpr_addr < GPR_BASE + 16'h0100)
		else $error("bank register outside bank area");
	a_irq_no_request: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!irq_req |=> !irq_accept)
		else $error("interrupt accepted without request");
endmodule

// ### design/cdr_pkg.sv
/*
 * cdr_pkg: constants and state type of the dedicated register set.
 * Assumes a single 50 MHz core clock and a synchronous active-high reset.
 */
package cdr_pkg;
	// ------------------------------------------------------------
	// register indices on the register port
	// ------------------------------------------------------------
	localparam logic [2:0] IDX_PC = 3'h0;
	localparam logic [2:0] IDX_ACC = 3'h1;
	localparam logic [2:0] IDX_TMP = 3'h2;
	localparam logic [2:0] IDX_IX = 3'h3;
	localparam logic [2:0] IDX_EP = 3'h4;
	localparam logic [2:0] IDX_SP = 3'h5;
	localparam logic [2:0] IDX_PSW = 3'h6;

	// ------------------------------------------------------------
	// status word layout
	// ------------------------------------------------------------
	localparam int CCR_H = 7;
	localparam int CCR_I = 6;
	localparam int CCR_IL_HI = 5;
	localparam int CCR_IL_LO = 4;
	localparam int CCR_N = 3;
	localparam int CCR_Z = 2;
	localparam int CCR_V = 1;
	localparam int CCR_C = 0;

	// ------------------------------------------------------------
	// reset values and address constants
	// ------------------------------------------------------------
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [4:0] RP_RESET = 5'h00;
	localparam logic [2:0] DP_RESET = 3'h0;
	localparam logic [7:0] CCR_RESET = 8'h30;
	localparam logic [15:0] DIR_WIN_BASE = 16'h0080;
	localparam logic [15:0] GPR_BASE = 16'h0100;

	// ------------------------------------------------------------
	// all state of the register set
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] pc;
		logic [15:0] acc;
		logic [15:0] tmp;
		logic [15:0] ix;
		logic [15:0] ep;
		logic [15:0] sp;
		logic [4:0] rp;
		logic [2:0] dp;
		logic [7:0] condition_flags;
		logic [15:0] rdata;
		logic [15:0] map_addr;
		logic [15:0] gpr_addr;
		logic irq_accept;
	} cdr_state_type;
endpackage

// ### sim/tb_cdr_regs.sv
/*
 * tb_cdr_regs: self-checking bench for the dedicated register set.
 * Assumes cdr_regs and cdr_pkg from design/ and one 50 MHz clock.
 */
`timescale 1ns/100ps
module tb_cdr_regs import cdr_pkg::*; ;
	// ------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0, reg_rd = 1'b0, pc_step = 1'b0, op_go = 1'b0;
	logic op_word = 1'b0, op_sub = 1'b0, op_shift = 1'b0;
	logic dir_req = 1'b0, gpr_req = 1'b0, irq_req = 1'b0;
	logic [7:0] dir_addr = 8'h00, gpr_opcode = 8'h00;
	logic [1:0] irq_level = 2'h0;
	logic [15:0] reg_rdata, map_addr, gpr_addr, pc_out, acc_out;
	logic [15:0] ix_out, ep_out, sp_out, psw_out, q;
	logic irq_accept;
	logic [7:0] dtab [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
	int miscompares = 0, comparisons = 0;

	cdr_regs dut_u (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .pc_step, .op_go, .op_word, .op_sub, .op_shift, .dir_req,
		.dir_addr, .map_addr, .gpr_req, .gpr_opcode, .gpr_addr, .irq_req,
		.irq_level, .irq_accept, .pc_out, .acc_out, .ix_out, .ep_out, .sp_out,
		.psw_out);

	// 50 MHz clock
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end

	// ------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the read edge
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// one-cycle pulse on pc_step, dir_req, gpr_req or irq_req with its operand
	task automatic strobe(input int s, input logic [7:0] v);
		@(posedge sys_clk);
		{pc_step, dir_req, gpr_req, irq_req} <= 4'h8 >> s;
		dir_addr <= v;
		gpr_opcode <= v;
		irq_level <= v[1:0];
		@(posedge sys_clk);
		{pc_step, dir_req, gpr_req, irq_req} <= 4'h0;
		#1;
	endtask

	// status word is set to its reset value first so unchanged flags have a known value
	task automatic op(input logic [15:0] a, t, input logic [2:0] m,
		input logic [15:0] ea, input logic [7:0] ef);
		wr(IDX_ACC, a);
		wr(IDX_TMP, t);
		wr(IDX_PSW, {8'h00, CCR_RESET});
		@(posedge sys_clk);
		{op_word, op_sub, op_shift} <= m;
		op_go <= 1'b1;
		@(posedge sys_clk);
		op_go <= 1'b0;
		#1 chk("acc_out", ea, acc_out);
		chk("flags", {8'h00, ef}, psw_out);
	endtask

	task automatic summarize();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		#1 chk("psw_out", 16'h0030, psw_out);
		chk("acc_out", REG_RESET, acc_out);
		rd(IDX_PSW, q);
		chk("psw read", 16'h0030, q);
		// every index written, index 7 must stay unmapped
		for (int i = 0; i < 8; i++) wr(i[2:0], 16'ha5c0 + 16'(i));
		for (int i = 0; i < 8; i++) begin
			rd(i[2:0], q);
			chk("reg read", (i == 7) ? 16'h0000 : 16'ha5c0 + 16'(i), q);
		end
		chk("pc_out", 16'ha5c0, pc_out);
		chk("ix_out", 16'ha5c3, ix_out);
		chk("ep_out", 16'ha5c4, ep_out);
		chk("sp_out", 16'ha5c5, sp_out);
		chk("psw_out", 16'ha5c6, psw_out);
		wr(IDX_PC, 16'hffff);
		strobe(0, 8'h00);
		chk("pc_out", 16'h0000, pc_out);
		strobe(0, 8'h00);
		chk("pc_out", 16'h0001, pc_out);
		// mode bits are word, sub, shift
		op(16'h000f, 16'h0001, 3'b000, 16'h0010, 8'hb0);
		op(16'h0040, 16'h0040, 3'b000, 16'h0080, 8'h3a);
		op(16'h007f, 16'h0001, 3'b000, 16'h0080, 8'hba);
		op(16'h12ff, 16'h3401, 3'b000, 16'h1200, 8'hb5);
		op(16'h0000, 16'h0001, 3'b010, 16'h00ff, 8'hb9);
		op(16'h0010, 16'h0001, 3'b010, 16'h000f, 8'hb0);
		op(16'h0005, 16'h0005, 3'b010, 16'h0000, 8'h34);
		op(16'h7fff, 16'h0001, 3'b100, 16'h8000, 8'hba);
		op(16'h8000, 16'h0001, 3'b110, 16'h7fff, 8'hb2);
		op(16'hffff, 16'h0001, 3'b100, 16'h0000, 8'hb5);
		op(16'h0081, 16'h0000, 3'b001, 16'h0002, 8'h31);
		// every window code against both edges of both halves
		for (int d = 0; d < 8; d++) begin
			wr(IDX_PSW, {5'h00, d[2:0], CCR_RESET});
			foreach (dtab[k]) begin
				strobe(1, dtab[k]);
				chk("map_addr", dtab[k][7] ? {5'h00, {1'b0, d[2:0]} + 4'h1, dtab[k][6:0]}
					: {8'h00, dtab[k]}, map_addr);
			end
		end
		for (int r = 0; r < 32; r += 31) begin
			wr(IDX_PSW, {r[4:0], 3'h0, CCR_RESET});
			for (int j = 0; j < 8; j++) begin
				strobe(2, {5'h1b, j[2:0]});
				chk("gpr_addr", GPR_BASE + {8'h00, r[4:0], j[2:0]}, gpr_addr);
			end
		end
		// enable flag, current level and request level in all combinations
		for (int n = 0; n < 32; n++) begin
			wr(IDX_PSW, {8'h00, 1'b0, n[4], n[3:2], 4'h0});
			strobe(3, {6'h00, n[1:0]});
			chk("irq_accept", {15'h0, n[4] && (n[1:0] < n[3:2])}, {15'h0, irq_accept});
		end
		summarize();
	end

	// watchdog: the sequence needs well under 1000 cycles
	initial begin
		#100000;
		miscompares++;
		summarize();
	end
endmodule
